// ---- design/rsi_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rsi_sync
   #(parameter int W = 1)
   (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
   );
   logic [W-1:0] meta;
   // First stage is read only by the second
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         meta <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// ---- design/rsi_top.sv ----
// Status indicator pins: front-end pair, rx stamp, buffer-empty indicator
`timescale 1ns/1ps
//
// Overview of operation
// - Front-end enable and busy-transmit: positive pin high, negative low.
// - Enabled, other states: positive low, negative high; swap at tx start.
// - Front-end enable clear: both front-end pins held low.
// - Trigger rise in PLL-ready enters busy-tx; modulation one symbol later.
// - Lead-time field shifts front-end pair timing relative to frame start.
// - Stamp enable: stamp pin rises on valid header, even if irq masked.
// - Stamp pin stays high until frame receive ends.
// - Stamp pin unused for stamping or antenna: driven low.
// - Buffer-empty mode after read command byte, ends on select high.
// - Buffer-empty indication valid 750 ns after last command clock.
// - Pin low when next byte available, high when not.
// - No interrupts shown while indicating; pending shown on release.
// - Receive error during read locks indication at empty.
// - Stamp plus antenna diversity: antenna pin antenna only, stamp pin.
// - Buffer-empty enable bit: 0 disabled, 1 enabled.
module rsi_top
   import rsi_pkg::*;
   #(parameter int LT_STEP_CYC = RSI_LT_STEP_CYC,
     parameter int SYMBOL_CYC = RSI_SYMBOL_CYC)
   (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic pll_ready_i,
   input wire logic sleep_tx_trigger_i,
   input wire logic tx_done_i,
   output logic busy_tx_o,
   output logic modulate_o,
   input wire logic phr_valid_i,
   input wire logic rx_end_i,
   input wire logic ant_div_en_i,
   input wire logic ant_sel_i,
   input wire logic fb_read_cmd_i,
   input wire logic spi_sel_b_i,
   input wire logic fb_byte_avail_i,
   input wire logic rx_error_i,
   input wire logic irq_line_i,
   output logic irq_pin_o,
   output logic antenna_sel_pin_o,
   output logic rx_stamp_pin_o,
   output logic fe_ctrl_pos_pin_o,
   output logic fe_ctrl_neg_pin_o
   );
   // ============================================================
   // Registers
   logic [7:0] radio_misc_control;
   logic [7:0] rf_tuning_control;
   logic fe_en, stamp_en, fb_en;
   logic [RSI_PA_LEAD_TIME_W-1:0] pa_lead_time;
   assign fe_en = radio_misc_control[RSI_FE_EN_BIT];
   assign stamp_en = radio_misc_control[RSI_STAMP_EN_BIT];
   assign fb_en = radio_misc_control[RSI_FB_IND_EN_BIT];
   assign pa_lead_time = rf_tuning_control[RSI_PA_LEAD_TIME_LSB +: RSI_PA_LEAD_TIME_W];

   // Register writes; all bits stored whole
   // Full byte kept
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         radio_misc_control <= RSI_MISC_CTRL_RST;
         rf_tuning_control <= RSI_RF_TUNE_RST;
      end
      else if (reg_wr_i && reg_addr_i == RSI_MISC_CTRL_ADDR)
         radio_misc_control <= reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == RSI_RF_TUNE_ADDR)
         rf_tuning_control <= reg_wdata_i;
   end

   // Read data registered; unmapped reads zero
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         reg_rdata_o <= 8'h00;
      else if (reg_addr_i == RSI_MISC_CTRL_ADDR)
         reg_rdata_o <= radio_misc_control;
      else if (reg_addr_i == RSI_RF_TUNE_ADDR)
         reg_rdata_o <= rf_tuning_control;
      else
         reg_rdata_o <= 8'h00;
   end

   // ============================================================
   // Pin synchronisers; select passes inverted so reset reads as idle
   logic trig_s, sel_s, sel_b_s, trig_d;
   rsi_sync #(.W(2)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_i({sleep_tx_trigger_i, ~spi_sel_b_i}),
      .sync_o({trig_s, sel_s})
   );
   assign sel_b_s = ~sel_s;

   // ============================================================
   // Transmit start sequence
   logic [15:0] sym_cnt;
   logic tx_start;
   assign tx_start = trig_s && !trig_d && pll_ready_i && !busy_tx_o;

   // Enter busy-tx, modulate one symbol later
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         trig_d <= 1'b0;
         busy_tx_o <= 1'b0;
         modulate_o <= 1'b0;
         sym_cnt <= 16'h0000;
      end
      else
      begin
         trig_d <= trig_s;
         if (tx_start)
         begin
            busy_tx_o <= 1'b1;
            sym_cnt <= 16'h0000;
         end
         else if (busy_tx_o && tx_done_i)
         begin
            busy_tx_o <= 1'b0;
            modulate_o <= 1'b0;
         end
         else if (busy_tx_o && !modulate_o)
         begin
            if (sym_cnt == 16'(SYMBOL_CYC - 1))
               modulate_o <= 1'b1;
            sym_cnt <= sym_cnt + 16'h0001;
         end
      end
   end

   // ============================================================
   // Front-end pair; lead time delays assertion after tx start
   logic fe_tx;
   logic [15:0] lt_target;
   assign lt_target = 16'(int'(pa_lead_time) * LT_STEP_CYC);

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         fe_tx <= 1'b0;
      else if (!busy_tx_o || tx_done_i) // Drop with the done strobe
         fe_tx <= 1'b0;
      else if (sym_cnt >= lt_target || modulate_o)
         fe_tx <= 1'b1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         fe_ctrl_pos_pin_o <= 1'b0;
         fe_ctrl_neg_pin_o <= 1'b0;
      end
      else
      begin
         fe_ctrl_pos_pin_o <= fe_en && fe_tx;
         fe_ctrl_neg_pin_o <= fe_en && !fe_tx;
      end
   end

   // ============================================================
   // Receive timestamp and antenna pins
   logic stamp_hold;
   // Rise on header, fall at frame end
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         stamp_hold <= 1'b0;
      else if (rx_end_i)
         stamp_hold <= 1'b0;
      else if (phr_valid_i && stamp_en)
         stamp_hold <= 1'b1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         rx_stamp_pin_o <= 1'b0;
         antenna_sel_pin_o <= 1'b0;
      end
      else
      begin
         antenna_sel_pin_o <= ant_div_en_i && ant_sel_i;
         if (stamp_en)
            rx_stamp_pin_o <= stamp_hold;
         else
            rx_stamp_pin_o <= ant_div_en_i && !ant_sel_i;
      end
   end

   // ============================================================
   // Buffer-empty indicator
   logic fb_mode, fb_valid, fb_lock;
   logic [7:0] fb_cnt;
   // Mode entered on command, left on select high
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         fb_mode <= 1'b0;
         fb_cnt <= 8'h00;
         fb_valid <= 1'b0;
      end
      else if (sel_b_s)
      begin
         fb_mode <= 1'b0;
         fb_valid <= 1'b0;
      end
      else if (fb_read_cmd_i && fb_en)
      begin
         fb_mode <= 1'b1;
         fb_cnt <= 8'h00;
         fb_valid <= 1'b0;
      end
      else if (fb_mode && !fb_valid)
      begin
         if (fb_cnt == 8'(RSI_FB_IND_CYC - 1))
            fb_valid <= 1'b1;
         fb_cnt <= fb_cnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         fb_lock <= 1'b0;
      else if (!fb_mode || sel_b_s) // Clear with mode, irq shows at once
         fb_lock <= 1'b0;
      else if (rx_error_i)
         fb_lock <= 1'b1;
   end

   // Pin: empty flag in mode, else irq at once
   always_comb
   begin
      if (fb_mode)
         irq_pin_o = !fb_valid || fb_lock || !fb_byte_avail_i;
      else
         irq_pin_o = irq_line_i;
   end

   // ============================================================
   // Checks
   fe_off_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         !fe_en |=> !fe_ctrl_pos_pin_o && !fe_ctrl_neg_pin_o)
      else $error("front-end pins not low when disabled");
   fe_tx_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         fe_en && modulate_o |=> fe_ctrl_pos_pin_o && !fe_ctrl_neg_pin_o)
      else $error("front-end pair wrong in transmit");
   fe_idle_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         fe_en && !busy_tx_o |=> !fe_ctrl_pos_pin_o && fe_ctrl_neg_pin_o)
      else $error("front-end pair wrong when idle");
   tx_mod_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         tx_start && !tx_done_i ##1 (!tx_done_i)[*8] |-> !modulate_o)
      else $error("modulation started too early");
   stamp_rise_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         phr_valid_i && stamp_en && !rx_end_i ##1 stamp_en
         |=> rx_stamp_pin_o)
      else $error("stamp pin did not rise");
   stamp_hold_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         rx_stamp_pin_o && stamp_en && $past(stamp_en) && !$past(rx_end_i)
         |=> rx_stamp_pin_o)
      else $error("stamp dropped before frame end");
   fb_early_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         $rose(fb_mode) |-> irq_pin_o [*8])
      else $error("buffer indication valid too early");
   fb_lock_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         fb_lock |-> irq_pin_o)
      else $error("locked indication not empty");
   fb_exit_a:
      assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
         sel_b_s |=> irq_pin_o == irq_line_i)
      else $error("interrupt not restored on release");
   tx_c: cover property (@(posedge core_clk_i) tx_start ##[1:300] modulate_o);
   stamp_c: cover property (@(posedge core_clk_i) $rose(rx_stamp_pin_o));
   fb_c: cover property (@(posedge core_clk_i) fb_valid && !irq_pin_o);
endmodule

// ---- dv/rsi_host_model.sv ----
// Host model: frame-buffer reader with empty-pin watch and timeout
`timescale 1ns/1ps
module rsi_host_model
   #(parameter int OCTET_CYC = 64)
   (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic irq_pin_i,
   output logic spi_sel_b_o,
   output logic fb_read_cmd_o,
   output logic abort_o,
   output int bytes_o
   );
   int ph;
   int hi_cnt;
   // =====================================
   // Read sequence: select, command, then bytes
   always_ff @(posedge clk_i)
   begin
      fb_read_cmd_o <= start_i && !abort_o && ph == 4;
      if (!rst_b_i || !start_i)
      begin
         spi_sel_b_o <= 1'b1;
         abort_o <= 1'b0;
         ph <= 0;
         hi_cnt <= 0;
         bytes_o <= rst_b_i ? bytes_o : 0;
      end
      else if (!abort_o)
      begin
         spi_sel_b_o <= 1'b0;
         ph <= ph + 1;
         if (ph > 4 && !irq_pin_i)
         begin
            bytes_o <= bytes_o + 1;
            hi_cnt <= 0;
         end
         else if (ph > 4)
            hi_cnt <= hi_cnt + 1;
         // give up after two octets empty
         if (hi_cnt > 2 * OCTET_CYC)
         begin
            abort_o <= 1'b1;
            spi_sel_b_o <= 1'b1;
         end
      end
   end
endmodule

// ---- dv/tb_rsi_top.sv ----
// Self-checking bench for the status indicator pin block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   n_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb_rsi_top
   import rsi_pkg::*;
   ;
   // Short counts keep the run brief
   localparam int LT = 2;
   localparam int SYM = 8;
   logic clk = 0, rst_b = 0, wr = 0, pll = 0, trig = 0, done = 0;
   logic phr = 0, rxe = 0, adiv = 0, asel = 0, avail = 0, rerr = 0;
   logic irql = 0, start_h = 0;
   logic [7:0] addr = '0, wd = '0, rd;
   logic busy, modu, irqp, antp, stp, pos, neg, sel_b, cmd, abort;
   int bytes, n_errors = 0, check_count = 0, cyc = 0, lead_cnt = 0;
   int d0, d3;
   always #4 clk = ~clk;
   rsi_top #(.LT_STEP_CYC(LT), .SYMBOL_CYC(SYM)) rsi_top_i (
      .core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr),
      .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd),
      .pll_ready_i(pll), .sleep_tx_trigger_i(trig), .tx_done_i(done),
      .busy_tx_o(busy), .modulate_o(modu), .phr_valid_i(phr),
      .rx_end_i(rxe), .ant_div_en_i(adiv), .ant_sel_i(asel),
      .fb_read_cmd_i(cmd), .spi_sel_b_i(sel_b), .fb_byte_avail_i(avail),
      .rx_error_i(rerr), .irq_line_i(irql), .irq_pin_o(irqp),
      .antenna_sel_pin_o(antp), .rx_stamp_pin_o(stp),
      .fe_ctrl_pos_pin_o(pos), .fe_ctrl_neg_pin_o(neg));
   rsi_host_model rsi_host_model_i (.clk_i(clk), .rst_b_i(rst_b),
      .start_i(start_h), .irq_pin_i(irqp), .spi_sel_b_o(sel_b),
      .fb_read_cmd_o(cmd), .abort_o(abort), .bytes_o(bytes));
   // =====================================
   // Helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      tick(2);
      #1;
      `CHK("rdata", e, rd)
   endtask
   task automatic settle(input int n);
      tick(n);
      #1;
   endtask
   task automatic stop_test();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Cycle ceiling and lead measurement
   always @(posedge clk)
   begin
      cyc++;
      if (busy === 1'b1 && pos !== 1'b1)
         lead_cnt++;
      if (cyc == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // =====================================
   // Scenarios
   task automatic t_regs();
      rreg(RSI_MISC_CTRL_ADDR, 8'h20);
      rreg(RSI_RF_TUNE_ADDR, 8'h00);
      wreg(8'h33, 8'hff);
      rreg(8'h33, 8'h00);
      wreg(RSI_MISC_CTRL_ADDR, 8'h2f);
      rreg(RSI_MISC_CTRL_ADDR, 8'h2f);
      `CHK("fe", 2'b00, {pos, neg})
   endtask
   task automatic t_tx(input logic [1:0] lt, output int d);
      int n;
      wreg(RSI_RF_TUNE_ADDR, {lt, 6'h00});
      wreg(RSI_MISC_CTRL_ADDR, 8'h80);
      settle(2);
      `CHK("fe idle", 2'b01, {pos, neg})
      // Trigger rises on an edge; two sync stages plus the busy_tx_o register
      tick(1);
      lead_cnt = 0;
      pll <= 1'b1;
      trig <= 1'b1;
      n = 0;
      while (busy !== 1'b1 && n < 20)
      begin
         settle(1);
         n++;
      end
      `CHK("busy", 3, n)
      n = 0;
      while (modu !== 1'b1 && n < 100)
      begin
         settle(1);
         n++;
      end
      `CHK("mod", SYM, n)
      `CHK("fe tx", 2'b10, {pos, neg})
      d = lead_cnt;
      tick(1);
      trig <= 1'b0;
      done <= 1'b1;
      tick(1);
      done <= 1'b0;
      settle(2);
      `CHK("fe done", 2'b01, {pos, neg})
      `CHK("busy end", 1'b0, busy)
      wreg(RSI_MISC_CTRL_ADDR, 8'h00);
      settle(2);
      `CHK("fe off", 2'b00, {pos, neg})
   endtask
   task automatic t_stamp();
      tick(1);
      adiv <= 1'b1;
      settle(3);
      `CHK("ant", 2'b01, {antp, stp})
      tick(1);
      adiv <= 1'b0;
      settle(3);
      `CHK("stamp off", 1'b0, stp)
      wreg(RSI_MISC_CTRL_ADDR, 8'h40);
      adiv <= 1'b1;
      asel <= 1'b1;
      settle(3);
      `CHK("ant stamp", 2'b10, {antp, stp})
      tick(1);
      phr <= 1'b1;
      tick(1);
      phr <= 1'b0;
      settle(2);
      `CHK("stamp up", 1'b1, stp)
      settle(20);
      `CHK("stamp hold", 1'b1, stp)
      tick(1);
      rxe <= 1'b1;
      tick(1);
      rxe <= 1'b0;
      settle(2);
      `CHK("stamp end", 1'b0, stp)
   endtask
   task automatic t_fb();
      int b;
      wreg(RSI_MISC_CTRL_ADDR, 8'h10);
      irql <= 1'b1;
      avail <= 1'b1;
      start_h <= 1'b1;
      settle(85);
      `CHK("fb wait", 1'b1, irqp)
      settle(30);
      `CHK("fb avail", 1'b0, irqp)
      b = bytes;
      tick(1);
      avail <= 1'b0;
      settle(2);
      `CHK("fb empty", 1'b1, irqp)
      `CHK("fb bytes", 1'b1, b > 0)
      tick(1);
      avail <= 1'b1;
      rerr <= 1'b1;
      tick(1);
      rerr <= 1'b0;
      settle(2);
      `CHK("fb lock", 1'b1, irqp)
      tick(1);
      irql <= 1'b0;
      settle(140);
      `CHK("abort", 1'b1, abort)
      `CHK("irq back", 1'b0, irqp)
      tick(1);
      irql <= 1'b1;
      settle(1);
      `CHK("irq pend", 1'b1, irqp)
      tick(1);
      start_h <= 1'b0;
      wreg(RSI_MISC_CTRL_ADDR, 8'h00);
      irql <= 1'b0;
      start_h <= 1'b1;
      // Look while an enabled indicator would still show empty
      settle(20);
      `CHK("fb off", 1'b0, irqp)
      tick(1);
      start_h <= 1'b0;
   endtask
   // =====================================
   // Main sequence
   initial
   begin
      tick(20);
      rst_b <= 1'b1;
      t_regs();
      t_tx(2'd0, d0);
      t_tx(2'd3, d3);
      `CHK("lead", 3 * LT, d3 - d0)
      t_stamp();
      t_fb();
      stop_test();
   end
endmodule

// ---- inc/rsi_pkg.sv ----
// Package for the radio status indicator pin block
package rsi_pkg;
   // Register map
   localparam logic [7:0] RSI_MISC_CTRL_ADDR = 8'h04;
   localparam logic [7:0] RSI_RF_TUNE_ADDR = 8'h16;
   localparam logic [7:0] RSI_MISC_CTRL_RST = 8'h20;
   localparam logic [7:0] RSI_RF_TUNE_RST = 8'h00;
   // Field positions in radio_misc_control
   localparam int RSI_FE_EN_BIT = 7;
   localparam int RSI_STAMP_EN_BIT = 6;
   localparam int RSI_FB_IND_EN_BIT = 4;
   // Lead-time field in rf_tuning_control
   localparam int RSI_PA_LEAD_TIME_LSB = 6;
   localparam int RSI_PA_LEAD_TIME_W = 2;
   // Timing
   localparam int RSI_CLK_PERIOD_PS = 8000;
   localparam int RSI_FB_IND_DELAY_PS = 750000;
   localparam int RSI_FB_IND_CYC =
      (RSI_FB_IND_DELAY_PS + RSI_CLK_PERIOD_PS - 1) / RSI_CLK_PERIOD_PS;
   localparam int RSI_LT_STEP_PS = 2000000;
   localparam int RSI_LT_STEP_CYC = RSI_LT_STEP_PS / RSI_CLK_PERIOD_PS;
   localparam int RSI_SYMBOL_PS = 16000000;
   localparam int RSI_SYMBOL_CYC = RSI_SYMBOL_PS / RSI_CLK_PERIOD_PS;
endpackage
